// File: epi_pkg.sv
// Package of constants and types for the external pin interrupt block
// Notes on behaviour
// - The pin acts as a request input only while the pin function enable bit is set.
// - Bit 3 is a read-only event flag that reads 1 once an event was seen.
// - Writing 1 to the acknowledge bit 2 clears the event flag, save while the pin is asserted in level mode or an edge is detected in the same cycle.
// - Writing 0 to the acknowledge bit does nothing and the bit always reads 0.
// - In edge-and-level mode an acknowledge cannot clear the flag while the pin is asserted.
// - Interrupt enable bit 1 gates the request, which is high whenever the flag is set while bit 1 is 1.
// - Detection mode bit 0 picks edges only (0) or edges and levels (1).
// - Polarity bit 5 picks falling edge and low level (0) or rising and high (1).
// - In edge-and-level mode the flag sets on assertion and stays set while asserted.
// - With the pin enabled the pullup is on while pull disable bit 6 is 0.
package epi_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] EPI_CTRL_ADDR = 8'h00;
	localparam logic [7:0] EPI_CTRL_RESET = 8'h00;
	localparam int EPI_BIT_MODE = 0;
	localparam int EPI_BIT_IE = 1;
	localparam int EPI_BIT_ACK = 2;
	localparam int EPI_BIT_FLAG = 3;
	localparam int EPI_BIT_PE = 4;
	localparam int EPI_BIT_POL = 5;
	localparam int EPI_BIT_PDD = 6;
	localparam int EPI_SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic pull_device_disable;
		logic polarity_select;
		logic pin_function_enable;
		logic event_interrupt_enable;
		logic detection_mode_select;
	} epi_ctrl_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} epi_bus_s;

endpackage : epi_pkg

// File: epi_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module epi_sync
	import epi_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic pin_async,
	output logic pin_sync
);
	logic s1;
	logic s2;
	logic s3;
	wire agree = (s2 == s3);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			pin_sync <= 1'b1;
		end else if (clk_en) begin
			s1 <= pin_async;
			s2 <= s1;
			s3 <= s2;
			if (agree) begin
				pin_sync <= s3;
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_SYNC_HOLD: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && (s2 != s3) |=> $stable(pin_sync))
		else $error("Synchroniser passed a disputed level");
	AST_SYNC_TAKE: assert property (@(posedge core_clk) disable iff (!reset_n)
		clk_en && (s2 == s3) |=> pin_sync == $past(s3))
		else $error("Synchroniser missed an agreed level");
endmodule : epi_sync

// File: epi_top.sv
// External pin interrupt block with control register and interrupt output
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module epi_top
	import epi_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic irq_pin,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq_out,
	output logic pullup_en
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	epi_ctrl_s ctrl;
	logic event_flag;
	logic pin_prev;
	logic pin_sync;

	epi_sync u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.pin_async(irq_pin),
		.pin_sync(pin_sync)
	);

	// Pin level matches the selected active sense
	function automatic logic is_active(input logic level, input logic pol);
		return level == pol;
	endfunction : is_active

	// ------------------------------------------------------------
	// Decode and detection
	// ------------------------------------------------------------
	wire hit = (reg_addr == EPI_CTRL_ADDR);
	wire wr_hit = reg_wr && hit;
	wire rd_hit = reg_rd && hit;
	wire ack_wr = wr_hit && reg_wdata[EPI_BIT_ACK];
	wire asserted = ctrl.pin_function_enable && is_active(pin_sync, ctrl.polarity_select);
	wire was_asserted = is_active(pin_prev, ctrl.polarity_select);
	wire edge_evt = asserted && !was_asserted;
	wire level_evt = ctrl.detection_mode_select && asserted;
	wire set_evt = edge_evt || level_evt;
	wire next_event_flag = set_evt || (event_flag && !ack_wr);
	wire [7:0] rd_value = {1'b0, ctrl.pull_device_disable, ctrl.polarity_select,
		ctrl.pin_function_enable, event_flag, 1'b0, ctrl.event_interrupt_enable,
		ctrl.detection_mode_select};
	wire next_irq = ctrl.event_interrupt_enable && next_event_flag;
	wire next_pullup = ctrl.pin_function_enable && !ctrl.pull_device_disable;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= '0;
			event_flag <= 1'b0;
			pin_prev <= 1'b1;
			reg_rdata <= 8'h00;
			irq_out <= 1'b0;
			pullup_en <= 1'b0;
		end else if (clk_en) begin
			if (wr_hit) begin
				ctrl <= {reg_wdata[EPI_BIT_PDD], reg_wdata[EPI_BIT_POL], reg_wdata[EPI_BIT_PE],
					reg_wdata[EPI_BIT_IE], reg_wdata[EPI_BIT_MODE]};
			end
			pin_prev <= pin_sync;
			event_flag <= next_event_flag;
			reg_rdata <= rd_hit ? rd_value : 8'h00;
			irq_out <= next_irq;
			pullup_en <= next_pullup;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	sequence s_ack;
		clk_en && ack_wr && !set_evt;
	endsequence

	AST_ENABLE_GATE: assert property (clk_en && !ctrl.pin_function_enable && !event_flag
		&& !ack_wr |=> !event_flag)
		else $error("Flag set while pin disabled");
	AST_FLAG_READ: assert property (clk_en && rd_hit |=> reg_rdata[3] == $past(event_flag))
		else $error("Flag readback wrong");
	AST_ACK_CLEAR: assert property (s_ack |=> !event_flag)
		else $error("Acknowledge did not clear flag");
	AST_ACK_READ0: assert property (reg_rdata[2] == 1'b0)
		else $error("Acknowledge bit read nonzero");
	AST_LEVEL_HOLD: assert property (clk_en && ctrl.detection_mode_select && asserted
		|=> event_flag)
		else $error("Flag cleared while level asserted");
	AST_IRQ: assert property (clk_en |=> irq_out == (ctrl.event_interrupt_enable && event_flag)
		|| $past(wr_hit))
		else $error("Interrupt output mismatch");
	AST_EDGE_SET: assert property (clk_en && edge_evt |=> event_flag)
		else $error("Edge missed");
	AST_POLARITY: assert property (clk_en && ctrl.pin_function_enable && !event_flag && !ack_wr
		&& pin_sync == ctrl.polarity_select && pin_prev != ctrl.polarity_select
		|=> event_flag)
		else $error("Polarity edge missed");
	AST_PULLUP: assert property (clk_en && !wr_hit |=> pullup_en == (ctrl.pin_function_enable
		&& !ctrl.pull_device_disable))
		else $error("Pullup control wrong");

	// ------------------------------------------------------------
	// Further checks
	// ------------------------------------------------------------
	sequence s_level_rise;
		clk_en && ctrl.detection_mode_select && edge_evt;
	endsequence

	sequence s_level_stay;
		clk_en && ctrl.detection_mode_select && asserted && ack_wr;
	endsequence

	AST_LEVEL_RISE_HOLD: assert property (s_level_rise ##1 s_level_stay |=> event_flag)
		else $error("Flag lost after level assertion");
	AST_DISABLED_NO_EVT: assert property (clk_en && !ctrl.pin_function_enable |-> !set_evt)
		else $error("Event raised while pin disabled");
	AST_FLAG_HOLD: assert property (clk_en && event_flag && !ack_wr |=> event_flag)
		else $error("Flag dropped without acknowledge");
	AST_SET_WINS: assert property (clk_en && set_evt |=> event_flag)
		else $error("Event lost against acknowledge");
	AST_ACK_ZERO: assert property (clk_en && wr_hit && !reg_wdata[EPI_BIT_ACK] && event_flag
		|=> event_flag)
		else $error("Zero acknowledge cleared flag");
	AST_IRQ_MASKED: assert property (clk_en && !wr_hit && !ctrl.event_interrupt_enable
		|=> !irq_out)
		else $error("Interrupt raised while masked");
	AST_IRQ_ON: assert property (clk_en && !wr_hit && ctrl.event_interrupt_enable
		&& next_event_flag |=> irq_out)
		else $error("Interrupt missing with flag set");
	AST_EDGE_ONLY_CLEAR: assert property (clk_en && !ctrl.detection_mode_select && ack_wr
		&& !edge_evt |=> !event_flag)
		else $error("Edge mode flag not cleared");
	AST_POL_FALL: assert property (clk_en && ctrl.pin_function_enable && !ctrl.polarity_select
		&& !pin_sync && pin_prev |=> event_flag)
		else $error("Falling edge missed");
	AST_PULLUP_OFF: assert property (clk_en && !wr_hit && !ctrl.pin_function_enable
		|=> !pullup_en)
		else $error("Pullup on while pin disabled");
	AST_CTRL_WRITE: assert property (clk_en && wr_hit |=>
		ctrl.pin_function_enable == $past(reg_wdata[EPI_BIT_PE])
		&& ctrl.polarity_select == $past(reg_wdata[EPI_BIT_POL])
		&& ctrl.pull_device_disable == $past(reg_wdata[EPI_BIT_PDD])
		&& ctrl.event_interrupt_enable == $past(reg_wdata[EPI_BIT_IE])
		&& ctrl.detection_mode_select == $past(reg_wdata[EPI_BIT_MODE]))
		else $error("Control write not taken");
	AST_IDLE_RDATA: assert property (clk_en && !rd_hit |=> reg_rdata == 8'h00)
		else $error("Read data without read");
	AST_RDATA_TOP: assert property (reg_rdata[7] == 1'b0)
		else $error("Reserved bit read nonzero");
	AST_FREEZE: assert property (!clk_en |=> $stable(ctrl) && $stable(event_flag)
		&& $stable(reg_rdata) && $stable(irq_out) && $stable(pullup_en))
		else $error("State moved while clock enable low");
endmodule : epi_top

// File: epi_pin_src.sv
// Model of the signal source on the interrupt pin
`timescale 1ns/10ps
module epi_pin_src (
	input wire logic drive_en,
	input wire logic drive_val,
	input wire logic pull_up,
	output logic irq_pin
);
	// Released pin: pull-up level, else floats away from last drive
	assign irq_pin = drive_en ? drive_val : (pull_up ? 1'b1 : !drive_val);
endmodule : epi_pin_src

// File: tb.sv
// Self-checking testbench for the external pin interrupt block
`timescale 1ns/10ps
module tb;
	import epi_pkg::*;
	logic core_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, d_en = 1, d_val = 1, ce = 1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic irq_out, pullup_en, irq_pin;
	int num_errors = 0, n_tests = 0, cyc = 0;
	always #20 core_clk = ~core_clk;
	epi_pin_src src (.drive_en(d_en), .drive_val(d_val), .pull_up(pullup_en), .irq_pin(irq_pin));
	epi_top uut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(ce), .irq_pin(irq_pin),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_out(irq_out), .pullup_en(pullup_en));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : rd
	// Drive or release the pin, then let the synchroniser settle
	task automatic pin(input logic en, input logic v);
		@(posedge core_clk);
		d_en <= en;
		d_val <= v;
		repeat (8) @(posedge core_clk);
	endtask : pin
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(EPI_CTRL_ADDR, EPI_CTRL_RESET);
		rd(8'h01, 8'h00);
		wr(8'h00, 8'h16);
		rd(8'h00, 8'h12);
		chk({6'h00, irq_out, pullup_en}, 8'h01);
		pin(1'b1, 1'b0);
		rd(8'h00, 8'h1a);
		chk({6'h00, irq_out, pullup_en}, 8'h03);
		wr(8'h00, 8'h12);
		rd(8'h00, 8'h1a);
		wr(8'h00, 8'h16);
		rd(8'h00, 8'h12);
		chk({6'h00, irq_out, pullup_en}, 8'h01);
		wr(8'h00, 8'h13);
		rd(8'h00, 8'h1b);
		wr(8'h00, 8'h17);
		rd(8'h00, 8'h1b);
		pin(1'b0, 1'b1);
		wr(8'h00, 8'h17);
		rd(8'h00, 8'h13);
		pin(1'b1, 1'b1);
		wr(8'h00, 8'h75);
		rd(8'h00, 8'h79);
		chk({6'h00, irq_out, pullup_en}, 8'h00);
		pin(1'b1, 1'b0);
		wr(8'h00, 8'h75);
		rd(8'h00, 8'h71);
		wr(8'h00, 8'h30);
		pin(1'b0, 1'b1);
		rd(8'h00, 8'h38);
		@(posedge core_clk);
		ce <= 1'b0;
		wr(8'h00, 8'h04);
		ce <= 1'b1;
		rd(8'h00, 8'h38);
		wr(8'h00, 8'h04);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b1);
		rd(8'h00, 8'h00);
		chk({6'h00, irq_out, pullup_en}, 8'h00);
		wr(8'h00, 8'h12);
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		rd(EPI_CTRL_ADDR, EPI_CTRL_RESET);
		chk({6'h00, irq_out, pullup_en}, 8'h00);
		print_verdict();
	end
endmodule : tb
